// >>> rtl/art_timer.sv
// auto-reload timer with 16-bit and split 8-bit modes, register port
// assumes a register master using one-cycle strobes on clk_sys
`timescale 1ns/100ps
module art_timer (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // external oscillator
  input  wire logic       ext_osc,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // interrupt
  output logic            irq
);

  // ****************************************************************
  // clock enables
  // ****************************************************************
  logic tick_div12;
  logic tick_ext8;

  art_tick_gen u_tick (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .ext_osc    (ext_osc),
    .tick_div12 (tick_div12),
    .tick_ext8  (tick_ext8)
  );

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0] cnt_low_q,   cnt_low_d;
  logic [7:0] cnt_high_q,  cnt_high_d;
  logic [7:0] rld_low_q,   rld_low_d;
  logic [7:0] rld_high_q,  rld_high_d;
  logic       flag_high_q, flag_high_d;
  logic       flag_low_q,  flag_low_d;
  logic       low_ien_q,   low_ien_d;
  logic       split_q,     split_d;
  logic       run_q,       run_d;
  logic       ext_sel_q,   ext_sel_d;
  logic       mode_low_q,  mode_low_d;
  logic       mode_high_q, mode_high_d;
  logic       timer_ie_q,  timer_ie_d;
  logic [7:0] rdata_d;
  logic       irq_d;

  // ****************************************************************
  // count advance and overflow events
  // ****************************************************************
  logic       tick_low;
  logic       tick_high;
  logic       inc_low;
  logic       inc_high;
  logic       ovf_low;
  logic       ovf_high;
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic       wr_ctl;
  logic       wr_clr;

  always_comb begin
    tick_low  = art_pkg::pick_tick(mode_low_q, ext_sel_q, tick_div12, tick_ext8);
    tick_high = art_pkg::pick_tick(mode_high_q, ext_sel_q, tick_div12, tick_ext8);
    next_low  = cnt_low_q;
    next_high = cnt_high_q;
    inc_low   = 1'b0;
    inc_high  = 1'b0;
    ovf_low   = 1'b0;
    ovf_high  = 1'b0;
    if (split_q) begin
      inc_low  = tick_low;
      inc_high = run_q && tick_high;
      ovf_low  = inc_low && (cnt_low_q == 8'hff);
      ovf_high = inc_high && (cnt_high_q == 8'hff);
      if (inc_low) begin
        next_low = ovf_low ? rld_low_q : cnt_low_q + 8'h01;
      end
      if (inc_high) begin
        next_high = ovf_high ? rld_high_q : cnt_high_q + 8'h01;
      end
    end else begin
      inc_low  = run_q && tick_low;
      ovf_low  = inc_low && (cnt_low_q == 8'hff);
      ovf_high = ovf_low && (cnt_high_q == 8'hff);
      if (ovf_high) begin
        next_low  = rld_low_q;
        next_high = rld_high_q;
      end else if (inc_low) begin
        {next_high, next_low} = {cnt_high_q, cnt_low_q} + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // register writes, flags and read data
  // ****************************************************************
  always_comb begin
    wr_ctl      = reg_wr && (reg_addr == art_pkg::ADDR_CONTROL);
    wr_clr      = reg_wr && (reg_addr == art_pkg::ADDR_IRQ_CLEAR);
    cnt_low_d   = next_low;
    cnt_high_d  = next_high;
    rld_low_d   = rld_low_q;
    rld_high_d  = rld_high_q;
    flag_high_d = flag_high_q;
    flag_low_d  = flag_low_q;
    low_ien_d   = low_ien_q;
    split_d     = split_q;
    run_d       = run_q;
    ext_sel_d   = ext_sel_q;
    mode_low_d  = mode_low_q;
    mode_high_d = mode_high_q;
    timer_ie_d  = timer_ie_q;
    if (reg_wr) begin
      unique case (reg_addr)
        art_pkg::ADDR_COUNT_LOW: begin
          cnt_low_d = reg_wdata;
        end
        art_pkg::ADDR_COUNT_HIGH: begin
          cnt_high_d = reg_wdata;
        end
        art_pkg::ADDR_RELOAD_LOW: begin
          rld_low_d = reg_wdata;
        end
        art_pkg::ADDR_RELOAD_HIGH: begin
          rld_high_d = reg_wdata;
        end
        art_pkg::ADDR_CONTROL: begin
          low_ien_d = reg_wdata[art_pkg::BIT_LOW_IRQ_EN];
          split_d   = reg_wdata[art_pkg::BIT_SPLIT];
          run_d     = reg_wdata[art_pkg::BIT_RUN];
          ext_sel_d = reg_wdata[art_pkg::BIT_EXT_SELECT];
        end
        art_pkg::ADDR_CLOCK_CONTROL: begin
          mode_low_d  = reg_wdata[art_pkg::BIT_LOW_CLK_MODE];
          mode_high_d = reg_wdata[art_pkg::BIT_HIGH_CLK_MODE];
        end
        art_pkg::ADDR_IRQ_ENABLE: begin
          timer_ie_d = reg_wdata[art_pkg::BIT_TIMER_IRQ_EN];
        end
        default: begin
        end
      endcase
    end
    // software writes or clears the flags; hardware only ever sets them
    if (wr_ctl) begin
      flag_high_d = reg_wdata[art_pkg::BIT_HIGH_FLAG];
      flag_low_d  = reg_wdata[art_pkg::BIT_LOW_FLAG];
    end
    if (wr_clr) begin
      if (reg_wdata[art_pkg::BIT_HIGH_FLAG]) begin
        flag_high_d = 1'b0;
      end
      if (reg_wdata[art_pkg::BIT_LOW_FLAG]) begin
        flag_low_d = 1'b0;
      end
    end
    // a set in the same cycle as a clear wins
    if (ovf_high) begin
      flag_high_d = 1'b1;
    end
    if (ovf_low) begin
      flag_low_d = 1'b1;
    end
    // interrupt level from enabled flags
    irq_d = timer_ie_q && (flag_high_q || (low_ien_q && flag_low_q));
    // read data, one cycle after the strobe
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        art_pkg::ADDR_COUNT_LOW: begin
          rdata_d = cnt_low_q;
        end
        art_pkg::ADDR_COUNT_HIGH: begin
          rdata_d = cnt_high_q;
        end
        art_pkg::ADDR_RELOAD_LOW: begin
          rdata_d = rld_low_q;
        end
        art_pkg::ADDR_RELOAD_HIGH: begin
          rdata_d = rld_high_q;
        end
        art_pkg::ADDR_CONTROL: begin
          rdata_d = {flag_high_q, flag_low_q, low_ien_q, 1'b0,
                     split_q, run_q, 1'b0, ext_sel_q};
        end
        art_pkg::ADDR_IRQ_STATUS: begin
          rdata_d = {flag_high_q, flag_low_q, 6'h00};
        end
        art_pkg::ADDR_CLOCK_CONTROL: begin
          rdata_d = {6'h00, mode_high_q, mode_low_q};
        end
        art_pkg::ADDR_IRQ_ENABLE: begin
          rdata_d = {2'h0, timer_ie_q, 5'h00};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_low_q   <= art_pkg::RESET_BYTE;
      cnt_high_q  <= art_pkg::RESET_BYTE;
      rld_low_q   <= art_pkg::RESET_BYTE;
      rld_high_q  <= art_pkg::RESET_BYTE;
      flag_high_q <= 1'b0;
      flag_low_q  <= 1'b0;
      low_ien_q   <= 1'b0;
      split_q     <= 1'b0;
      run_q       <= 1'b0;
      ext_sel_q   <= 1'b0;
      mode_low_q  <= 1'b0;
      mode_high_q <= 1'b0;
      timer_ie_q  <= 1'b0;
      reg_rdata   <= art_pkg::RESET_BYTE;
      irq         <= 1'b0;
    end else begin
      cnt_low_q   <= cnt_low_d;
      cnt_high_q  <= cnt_high_d;
      rld_low_q   <= rld_low_d;
      rld_high_q  <= rld_high_d;
      flag_high_q <= flag_high_d;
      flag_low_q  <= flag_low_d;
      low_ien_q   <= low_ien_d;
      split_q     <= split_d;
      run_q       <= run_d;
      ext_sel_q   <= ext_sel_d;
      mode_low_q  <= mode_low_d;
      mode_high_q <= mode_high_d;
      timer_ie_q  <= timer_ie_d;
      reg_rdata   <= rdata_d;
      irq         <= irq_d;
    end
  end

endmodule

// >>> rtl/art_pkg.sv
// constants, register map and field layout of the auto-reload timer
// assumes a single system clock and an 8-bit register port
package art_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8e;
  localparam logic [7:0] ADDR_CONTROL       = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW    = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h95;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h96;
  localparam logic [7:0] ADDR_IRQ_CLEAR     = 8'h97;
  localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'ha8;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int BIT_HIGH_FLAG    = 7;
  localparam int BIT_LOW_FLAG     = 6;
  localparam int BIT_LOW_IRQ_EN   = 5;
  localparam int BIT_SPLIT        = 3;
  localparam int BIT_RUN          = 2;
  localparam int BIT_EXT_SELECT   = 0;
  localparam logic [7:0] CONTROL_USED_MASK = 8'hed;

  // clock control fields
  localparam int BIT_LOW_CLK_MODE  = 0;
  localparam int BIT_HIGH_CLK_MODE = 1;
  localparam logic [7:0] CLOCK_CONTROL_USED_MASK = 8'h03;

  // interrupt enable register field
  localparam int BIT_TIMER_IRQ_EN = 5;
  localparam logic [7:0] IRQ_ENABLE_USED_MASK = 8'h20;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;

  // ****************************************************************
  // per-byte tick selection
  // ****************************************************************
  function automatic logic pick_tick(input logic mode, input logic ext_sel,
                                     input logic tick_div12, input logic tick_ext8);
    if (mode) begin
      pick_tick = 1'b1;
    end else begin
      pick_tick = ext_sel ? tick_ext8 : tick_div12;
    end
  endfunction

endpackage

// >>> rtl/art_tick_gen.sv
// tick enables: system clock /12 and synchronised external oscillator /8
// assumes ext_osc is slower than half the system clock
`timescale 1ns/100ps
module art_tick_gen #(
  parameter int SYS_DIV = art_pkg::SYS_DIVIDE,
  parameter int EXT_DIV = art_pkg::EXT_DIVIDE
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // external oscillator
  input  wire logic ext_osc,
  // ticks
  output logic      tick_div12,
  output logic      tick_ext8
);

  // ****************************************************************
  // divider and synchroniser state
  // ****************************************************************
  logic [3:0] div_q,  div_d;
  logic [2:0] ecnt_q, ecnt_d;
  logic       sync1_q, sync2_q, sync3_q;
  logic       t12_d, t8_d;

  always_comb begin
    div_d  = div_q;
    ecnt_d = ecnt_q;
    t12_d  = 1'b0;
    t8_d   = 1'b0;
    if (div_q == 4'(SYS_DIV - 1)) begin
      div_d = 4'h0;
      t12_d = 1'b1;
    end else begin
      div_d = div_q + 4'h1;
    end
    if (sync2_q && !sync3_q) begin
      if (ecnt_q == 3'(EXT_DIV - 1)) begin
        ecnt_d = 3'h0;
        t8_d   = 1'b1;
      end else begin
        ecnt_d = ecnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_q      <= 4'h0;
      ecnt_q     <= 3'h0;
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      sync3_q    <= 1'b0;
      tick_div12 <= 1'b0;
      tick_ext8  <= 1'b0;
    end else begin
      div_q      <= div_d;
      ecnt_q     <= ecnt_d;
      sync1_q    <= ext_osc;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      tick_div12 <= t12_d;
      tick_ext8  <= t8_d;
    end
  end

endmodule

// >>> tb/art_timer_assertions.sv
// checker on the register port and interrupt of art_timer
// assumes a single clock clk_sys and active high reset
`timescale 1ns/100ps
module art_timer_assertions (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // watched ports
  input wire logic       ext_osc,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq
);
  logic       rd_q;
  logic [7:0] a_q;
  logic       hi_q;
  logic       hi_d;
  logic       ie_q;
  logic       ie_d;
  logic       ctl_rd;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  assign ctl_rd = reg_rd && reg_addr == art_pkg::ADDR_CONTROL;
  // ****************************************************************
  // helper state
  // ****************************************************************
  always_comb begin
    hi_d = hi_q;
    ie_d = ie_q;
    if (rd_q && a_q == art_pkg::ADDR_CONTROL && reg_rdata[7]) begin
      hi_d = 1'b1;
    end
    if (reg_wr && reg_addr inside {art_pkg::ADDR_CONTROL, art_pkg::ADDR_IRQ_CLEAR}) begin
      hi_d = 1'b0;
    end
    if (reg_wr && reg_addr == art_pkg::ADDR_IRQ_ENABLE) begin
      ie_d = reg_wdata[5];
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_q <= 1'b0;
      a_q  <= 8'h00;
      hi_q <= 1'b0;
      ie_q <= 1'b0;
    end else begin
      rd_q <= reg_rd;
      a_q  <= reg_addr;
      hi_q <= hi_d;
      ie_q <= ie_d;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  rdata_idle_a: assert property (!rd_q |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unused_zero_a: assert property (rd_q && a_q == art_pkg::ADDR_CONTROL |->
    reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0) else $error("unused control bit set");
  unmapped_zero_a: assert property (rd_q && !(a_q inside {8'h8e, 8'h91, 8'h92, 8'h93,
    8'h94, 8'h95, 8'h96, 8'h97, 8'ha8}) |-> reg_rdata == 8'h00) else $error("unmapped read");
  flag_write_a: assert property (reg_wr && reg_addr == art_pkg::ADDR_CONTROL &&
    reg_wdata[7:6] == 2'b11 ##1 ctl_rd |=> reg_rdata[7:6] == 2'b11) else $error("flag write");
  flag_sticky_a: assert property (rd_q && a_q == art_pkg::ADDR_CONTROL && hi_q |->
    reg_rdata[7]) else $error("high flag cleared without software");
  irq_status_a: assert property (reg_rd && reg_addr == art_pkg::ADDR_IRQ_STATUS && irq &&
    !$past(reg_wr) |=> reg_rdata[7:6] != 2'b00) else $error("irq without a flag");
  irq_off_a: assert property (!$past(ie_q) |-> !irq)
    else $error("irq while timer interrupt disabled");
  irq_drop_a: assert property (reg_wr && reg_addr == art_pkg::ADDR_IRQ_ENABLE &&
    !reg_wdata[5] |=> ##1 !irq) else $error("irq not dropped");
  cover property (rd_q && a_q == art_pkg::ADDR_CONTROL && hi_q);
  cover property ($rose(irq));
  cover property (reg_wr && reg_addr == art_pkg::ADDR_CONTROL ##1 ctl_rd);
endmodule
bind art_timer art_timer_assertions u_chk (.clk_sys(clk_sys), .reset(reset), .ext_osc(ext_osc),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq));

// >>> tb/art_timer_tb.sv
// self-checking bench for art_timer over its register port
// assumes the checker is bound from its own file
`timescale 1ns/100ps
module art_timer_tb;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       ext_osc = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       irq;
  logic [7:0] v;
  int         n_fail = 0;
  int         n_compared = 0;
  always #2.5 clk_sys = ~clk_sys;
  art_timer dut (.clk_sys(clk_sys), .reset(reset), .ext_osc(ext_osc), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(nm, v, exp);
  endtask
  task automatic waitf(input logic [7:0] m);
    for (int i = 0; i < 100; i++) begin
      rd(8'h91);
      if ((v & m) !== 8'h00) begin
        return;
      end
    end
    chk("flag_wait", 8'h00, m);
    test_done();
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    idle(16);
    reset <= 1'b0;
    idle(1);
    rc("ctl_rst", 8'h91, 8'h00);
    rc("cnt_rst", 8'h95, 8'h00);
    wr(8'h50, 8'h5a);
    rc("unmapped", 8'h50, 8'h00);
    wr(8'h91, 8'hff);
    rc("ctl_used", 8'h91, 8'hed);
    wr(8'h91, 8'h00);
    wr(8'h8e, 8'h01);
    wr(8'h93, 8'h80);
    wr(8'h94, 8'hf0);
    wr(8'h95, 8'hff);
    wr(8'h91, 8'h04);
    waitf(8'h80);
    wr(8'h91, 8'hc0);
    rc("reload16", 8'h95, 8'h80);
    idle(300);
    rc("sticky", 8'h91, 8'hc0);
    wr(8'ha8, 8'h20);
    idle(2);
    chk("irq16", {7'h0, irq}, 8'h01);
    rc("status", 8'h96, 8'hc0);
    wr(8'h97, 8'hc0);
    idle(1);
    chk("irq_clr", {7'h0, irq}, 8'h00);
    wr(8'h95, 8'h00);
    wr(8'h94, 8'hf0);
    wr(8'h91, 8'h24);
    waitf(8'h40);
    chk("no_hi16", v & 8'h80, 8'h00);
    idle(1);
    chk("irq_low16", {7'h0, irq}, 8'h01);
    wr(8'h92, 8'hf8);
    wr(8'h94, 8'hf8);
    wr(8'h95, 8'h55);
    wr(8'h91, 8'h08);
    waitf(8'h40);
    chk("split_hi", v & 8'h80, 8'h00);
    idle(1);
    chk("irq_split", {7'h0, irq}, 8'h00);
    rc("hold_hi", 8'h95, 8'h55);
    rd(8'h94);
    chk("lo_reload", {7'h0, v >= 8'hf8}, 8'h01);
    wr(8'h91, 8'h28);
    idle(12);
    chk("irq_lo", {7'h0, irq}, 8'h01);
    wr(8'h93, 8'ha0);
    wr(8'h8e, 8'h03);
    wr(8'h95, 8'hfe);
    wr(8'h91, 8'h0c);
    waitf(8'h80);
    wr(8'h91, 8'h08);
    rd(8'h95);
    chk("hi_reload", {7'h0, v >= 8'ha0 && v < 8'ha8}, 8'h01);
    wr(8'ha8, 8'h00);
    wr(8'h8e, 8'h00);
    wr(8'h91, 8'h00);
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h04);
    idle(120);
    wr(8'h91, 8'h00);
    rd(8'h94);
    chk("div12", {7'h0, v >= 8'h09 && v <= 8'h0b}, 8'h01);
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h05);
    repeat (16) begin
      ext_osc <= 1'b1;
      idle(4);
      ext_osc <= 1'b0;
      idle(4);
    end
    idle(8);
    wr(8'h91, 8'h01);
    rc("ext8", 8'h94, 8'h02);
    test_done();
  end
endmodule
